// file: rtl/usr_suspend_resume.v
// usr_suspend_resume.v: suspend detect, sleep entry and wake-up sequencer with apb registers
// assumes pclk 40 MHz free running; usb line and pin inputs are asynchronous to pclk
// limitation: clocks restart on a pclk edge after the stabilization count, not asynchronously
`timescale 1ns/1ps
`include "usr_defines.vh"

module usr_suspend_resume #(
    parameter STABLE_CYC = `USR_STABLE_US * `USR_CLK_MHZ,
    parameter IDLE_CYC = `USR_IDLE_US * `USR_CLK_MHZ,
    parameter RWU_WAIT_CYC = `USR_RWU_WAIT_US * `USR_CLK_MHZ,
    parameter RESUME_K_CYC = `USR_RESUME_K_US * `USR_CLK_MHZ
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // usb line state and resume drive
    input wire line_j,
    input wire line_k,
    output reg drive_k,
    // application pins
    input wire remote_wake_request_n,
    output reg sleep_indicator_n,
    output reg clocks_enabled,
    output wire interrupt_request_n,
    output wire irq_oe,
    output wire frame_start_oe,
    output wire data_bus_oe,
    output wire bus_reset_oe,
    output wire data_set_oe,
    output wire pullup_supply_out,
    output wire settle_busy
);

    // sequencer states
    localparam ST_RUN = 3'h0;
    localparam ST_SLEEP = 3'h1;
    localparam ST_STABLE = 3'h2;
    localparam ST_RWU_WAIT = 3'h3;
    localparam ST_DRIVE_K = 3'h4;

    reg [2:0] state;
    reg [31:0] timer;
    reg [31:0] idle_cnt;
    reg [4:0] settle_cnt;
    reg remote_wake;
    reg wake_pending;
    reg lockout;
    // sleep_status_register
    reg sleep_status_control_bit;
    reg wake_complete_flag;
    reg powered_off_peripherals_cfg;
    // system_control_register
    reg soft_restart_bit;
    reg sleep_interrupt_enable;
    // misc_control_status_register
    reg extended_feature_enable;
    reg board_signal_feature_enable;
    reg pullup_supply_enable;
    reg post_sleep_lockout_enable;
    // general_purpose_register
    reg wake_interrupt_enable;
    reg [30:0] gp_spare;
    reg [31:0] rdata;
    // three-stage pin synchronisers
    // the first flop only feeds the second; decisions use the second and third
    reg [2:0] j_sync;
    reg [2:0] k_sync;
    reg [2:0] rwu_sync;

    function stable_low;
        input [2:0] s;
        begin
            stable_low = ~s[1] & ~s[2];
        end
    endfunction

    function stable_high;
        input [2:0] s;
        begin
            stable_high = s[1] & s[2];
        end
    endfunction

    // one decode shared by the read mux, the write path and the error flag
    function reg_hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    wire asleep = (state == ST_SLEEP);
    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & penable & ~pwrite;
    wire k_seen = stable_high(k_sync);
    wire j_seen = stable_high(j_sync);
    wire rwu_seen = stable_low(rwu_sync);

    // address decode
    wire hit_ssr = reg_hit(paddr, `USR_OFS_SLEEP_STATUS);
    wire hit_scr = reg_hit(paddr, `USR_OFS_SYS_CTRL);
    wire hit_misc_control_status_register = reg_hit(paddr, `USR_OFS_MISC_CTRL);
    wire hit_gp = reg_hit(paddr, `USR_OFS_GP);
    wire hit_st = reg_hit(paddr, `USR_OFS_STATE);
    wire mapped = hit_ssr | hit_scr | hit_misc_control_status_register | hit_gp | hit_st;
    // only soft restart may land in sleep; lockout drops all writes until cleared
    wire wr_ok = wr_en & mapped & ~lockout & (~asleep | hit_scr);
    wire soft_wake = asleep & wr_en & hit_scr & extended_feature_enable
        & pwdata[`USR_SCR_SOFT_RESTART];

    // suspend condition: j long enough, masked while the wake flag stands
    wire suspend_seen = (state == ST_RUN) && (idle_cnt == IDLE_CYC - 1) && j_seen
        && !wake_complete_flag;
    wire stable_done = (state == ST_STABLE) && (timer == 32'h0);
    wire wake_trigger = k_seen | rwu_seen | soft_wake | wake_pending;

    // single-cycle apb, write taken at the access edge
    assign pready = 1'b1;
    // unmapped offsets answer with an error, never a hang
    assign pslverr = psel & penable & ~mapped;
    assign prdata = rdata;

    // read mux
    always @* begin
        rdata = 32'h0000_0000;
        if (hit_ssr) begin
            rdata[`USR_SSR_SLEEP] = sleep_status_control_bit;
            rdata[`USR_SSR_WAKE] = wake_complete_flag;
            rdata[`USR_SSR_PO] = powered_off_peripherals_cfg;
        end else if (hit_scr) begin
            rdata[`USR_SCR_SOFT_RESTART] = soft_restart_bit;
            rdata[`USR_SCR_SLEEP_IE] = sleep_interrupt_enable;
        end else if (hit_misc_control_status_register) begin
            rdata[`USR_MISC_CONTROL_STATUS_REGISTER_EXTENDED_FEATURE_ENABLE] = extended_feature_enable;
            rdata[`USR_MISC_CONTROL_STATUS_REGISTER_BOARD_SIGNAL_FEATURE_ENABLE] = board_signal_feature_enable;
            rdata[`USR_MISC_CONTROL_STATUS_REGISTER_PULLUP_SUPPLY_ENABLE] = pullup_supply_enable;
            rdata[`USR_MISC_CONTROL_STATUS_REGISTER_LOCKOUT] = post_sleep_lockout_enable;
        end else if (hit_gp) begin
            rdata = {gp_spare, wake_interrupt_enable};
        end else if (hit_st) begin
            rdata = {27'h0000000, lockout, remote_wake, state};
        end
    end // reads have no side effects, so they stay legal asleep

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            j_sync <= 3'h0;
            k_sync <= 3'h0;
            rwu_sync <= 3'h7;
        end else begin
            j_sync <= {j_sync[1:0], line_j};
            k_sync <= {k_sync[1:0], line_k};
            rwu_sync <= {rwu_sync[1:0], remote_wake_request_n};
        end
    end

    // register file
    // refused writes are dropped while pready still answers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_status_control_bit <= 1'b0;
            wake_complete_flag <= 1'b0;
            powered_off_peripherals_cfg <= 1'b0;
            soft_restart_bit <= 1'b0;
            sleep_interrupt_enable <= 1'b0;
            extended_feature_enable <= 1'b0;
            board_signal_feature_enable <= 1'b0;
            pullup_supply_enable <= 1'b0;
            post_sleep_lockout_enable <= 1'b0;
            wake_interrupt_enable <= 1'b0;
            gp_spare <= 31'h00000000;
            settle_cnt <= 5'h00;
        end else begin
            if (settle_cnt != 5'h00)
                settle_cnt <= settle_cnt - 5'h01;
            if (wr_ok && hit_ssr) begin
                sleep_status_control_bit <= pwdata[`USR_SSR_SLEEP];
                wake_complete_flag <= wake_complete_flag & pwdata[`USR_SSR_WAKE];
                powered_off_peripherals_cfg <= pwdata[`USR_SSR_PO];
            end
            if (wr_ok && hit_scr) begin
                soft_restart_bit <= pwdata[`USR_SCR_SOFT_RESTART];
                if (!asleep)
                    sleep_interrupt_enable <= pwdata[`USR_SCR_SLEEP_IE];
            end
            if (wr_ok && hit_misc_control_status_register) begin
                extended_feature_enable <= pwdata[`USR_MISC_CONTROL_STATUS_REGISTER_EXTENDED_FEATURE_ENABLE];
                board_signal_feature_enable <= pwdata[`USR_MISC_CONTROL_STATUS_REGISTER_BOARD_SIGNAL_FEATURE_ENABLE];
                pullup_supply_enable <= pwdata[`USR_MISC_CONTROL_STATUS_REGISTER_PULLUP_SUPPLY_ENABLE];
                post_sleep_lockout_enable <= pwdata[`USR_MISC_CONTROL_STATUS_REGISTER_LOCKOUT];
                settle_cnt <= `USR_SETTLE_CYC;
            end
            if (wr_ok && hit_gp) begin
                wake_interrupt_enable <= pwdata[`USR_GP_WAKE_IE];
                gp_spare <= pwdata[31:1];
            end
            // suspend detect: set wins over write; held off while wake flag stands
            if (suspend_seen)
                sleep_status_control_bit <= 1'b1;
            if (state != ST_SLEEP && state != ST_RUN)
                sleep_status_control_bit <= 1'b0;
            if (stable_done)
                wake_complete_flag <= 1'b1;
        end
    end

    // j-state idle counter
    // holds at the threshold instead of wrapping on a long idle bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            idle_cnt <= 32'h0;
        else if (state != ST_RUN || !j_seen)
            idle_cnt <= 32'h0;
        else if (idle_cnt != IDLE_CYC - 1)
            idle_cnt <= idle_cnt + 32'h1;
    end

    // sleep and wake sequencer
    // one shared down-counter, loaded on entry to ST_STABLE, ST_RWU_WAIT and ST_DRIVE_K
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RUN;
            timer <= 32'h0;
            remote_wake <= 1'b0;
            wake_pending <= 1'b0;
            lockout <= 1'b0;
            sleep_indicator_n <= 1'b1;
            clocks_enabled <= 1'b1;
            drive_k <= 1'b0;
        end else begin
            if (timer != 32'h0)
                timer <= timer - 32'h1;
            // lockout ends with the first clean idle cycle on the strobes
            if (lockout && !psel)
                lockout <= 1'b0;
            case (state)
                ST_RUN: begin
                    wake_pending <= 1'b0;
                    // clearing write of the sleep bit enters sleep at once
                    if (wr_ok && hit_ssr && sleep_status_control_bit
                        && !pwdata[`USR_SSR_SLEEP]) begin
                        state <= ST_SLEEP;
                        sleep_indicator_n <= 1'b0;
                        clocks_enabled <= 1'b0;
                        // a trigger already standing at entry is kept, not lost
                        wake_pending <= k_seen | rwu_seen;
                        remote_wake <= rwu_seen;
                    end
                end
                ST_SLEEP: begin
                    // triggers latched so a glitch-length request still completes
                    if (wake_trigger) begin
                        state <= ST_STABLE;
                        wake_pending <= 1'b0;
                        sleep_indicator_n <= 1'b1;
                        remote_wake <= rwu_seen | (remote_wake & wake_pending);
                        timer <= STABLE_CYC - 1;
                        lockout <= post_sleep_lockout_enable;
                    end
                end
                ST_STABLE: begin
                    if (stable_done) begin
                        clocks_enabled <= 1'b1;
                        if (remote_wake) begin
                            state <= ST_RWU_WAIT;
                            // minus what stabilization already used
                            timer <= RWU_WAIT_CYC - STABLE_CYC;
                        end else begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_RWU_WAIT: begin
                    if (timer == 32'h0) begin
                        state <= ST_DRIVE_K;
                        drive_k <= 1'b1;
                        timer <= RESUME_K_CYC - 1;
                    end
                end
                ST_DRIVE_K: begin
                    // k ends on its own; firmware needs no stop write
                    if (timer == 32'h0) begin
                        drive_k <= 1'b0;
                        state <= ST_RUN;
                        remote_wake <= 1'b0;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // interrupt from sleep status or wake completion
    wire irq = (wake_complete_flag & wake_interrupt_enable)
        | (sleep_status_control_bit & sleep_interrupt_enable);
    // low enables release pins so a powered-off neighbour never sees a high
    wire tri_po = ~sleep_indicator_n & powered_off_peripherals_cfg;

    assign interrupt_request_n = ~irq;
    assign irq_oe = ~tri_po;
    assign frame_start_oe = ~tri_po;
    assign data_bus_oe = ~tri_po & rd_en;
    assign bus_reset_oe = sleep_indicator_n | board_signal_feature_enable;
    assign data_set_oe = sleep_indicator_n | board_signal_feature_enable;
    assign pullup_supply_out = pullup_supply_enable;
    assign settle_busy = (settle_cnt != 5'h00);

endmodule // usr_suspend_resume

// file: rtl/usr_defines.vh
// usr_defines.vh: offsets, fields and timing for the suspend/resume sequencer
// assumes inclusion by usr_suspend_resume.v only
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH

// register byte offsets
`define USR_OFS_SLEEP_STATUS 12'h000
`define USR_OFS_SYS_CTRL 12'h004
`define USR_OFS_MISC_CTRL 12'h008
`define USR_OFS_GP 12'h00c
`define USR_OFS_STATE 12'h010

// sleep_status_register fields
`define USR_SSR_SLEEP 0
`define USR_SSR_WAKE 1
`define USR_SSR_PO 2
// system_control_register fields
`define USR_SCR_SOFT_RESTART 0
`define USR_SCR_SLEEP_IE 1
// misc_control_status_register fields
`define USR_MISC_CONTROL_STATUS_REGISTER_EXTENDED_FEATURE_ENABLE 0
`define USR_MISC_CONTROL_STATUS_REGISTER_BOARD_SIGNAL_FEATURE_ENABLE 1
`define USR_MISC_CONTROL_STATUS_REGISTER_PULLUP_SUPPLY_ENABLE 2
`define USR_MISC_CONTROL_STATUS_REGISTER_LOCKOUT 3
// general_purpose_register fields
`define USR_GP_WAKE_IE 0

// timing: clock in MHz, delays in microseconds, settle in cycles
`define USR_CLK_MHZ 40
`define USR_STABLE_US 6000
`define USR_IDLE_US 3000
`define USR_RWU_WAIT_US 7000
`define USR_RESUME_K_US 12000
`define USR_SETTLE_CYC 5'h10

`endif

// file: testbench/usr_props.sv
// usr_props.sv: port-level assertions for the suspend/resume sequencer
// assumes binding into usr_suspend_resume with the same cycle parameters
`timescale 1ns/1ps
module usr_props #(
    parameter STABLE_CYC = 20,
    parameter RWU_WAIT_CYC = 30,
    parameter RESUME_K_CYC = 20
) (
    // clock, reset, bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    // line and pins
    input wire line_k,
    input wire remote_wake_request_n,
    input wire drive_k,
    input wire sleep_indicator_n,
    input wire clocks_enabled,
    input wire irq_oe,
    input wire frame_start_oe,
    input wire data_bus_oe,
    input wire bus_reset_oe,
    input wire data_set_oe
);
    logic [19:0] wake_cnt;
    logic [19:0] k_cnt;
    // wake_cnt saturates; 20 bits hold the long default counts without wrap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt <= 20'h00000;
            k_cnt <= 20'h00000;
        end else begin
            wake_cnt <= !sleep_indicator_n ? 20'h00000 : wake_cnt + {19'h00000, ~&wake_cnt};
            k_cnt <= drive_k ? k_cnt + 20'h00001 : 20'h00000;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access without ready");
    a_sleep_gates: assert property (!sleep_indicator_n |-> !clocks_enabled)
        else $error("clocks running while asleep");
    a_host_wake: assert property (!sleep_indicator_n && line_k |-> ##[1:6] sleep_indicator_n)
        else $error("no wake on host resume");
    a_remote_wake: assert property (!sleep_indicator_n && !remote_wake_request_n
        |-> ##[1:6] sleep_indicator_n)
        else $error("no wake on remote request");
    a_stable_time: assert property ($rose(clocks_enabled)
        |-> wake_cnt >= STABLE_CYC - 2 && wake_cnt <= STABLE_CYC + 2)
        else $error("clock restore time wrong");
    a_k_wait: assert property ($rose(drive_k) |-> wake_cnt >= RWU_WAIT_CYC - 1)
        else $error("resume drive too early");
    a_k_length: assert property ($fell(drive_k)
        |-> k_cnt >= RESUME_K_CYC - 1 && k_cnt <= RESUME_K_CYC + 1)
        else $error("resume drive length wrong");
    a_k_awake: assert property (drive_k |-> sleep_indicator_n && clocks_enabled)
        else $error("resume drive while clocks off");
    a_po_pins: assert property (!frame_start_oe || !irq_oe
        |-> !sleep_indicator_n && irq_oe == frame_start_oe && !data_bus_oe)
        else $error("peripheral pins released outside sleep");
    a_board_pins: assert property (sleep_indicator_n |-> bus_reset_oe && data_set_oe)
        else $error("board pins released while awake");
    c_wake: cover property ($rose(clocks_enabled));
    c_k_done: cover property ($fell(drive_k));
    c_po_sleep: cover property (!frame_start_oe);
endmodule // usr_props

bind usr_suspend_resume usr_props #(.STABLE_CYC(STABLE_CYC), .RWU_WAIT_CYC(RWU_WAIT_CYC),
    .RESUME_K_CYC(RESUME_K_CYC)) u_usr_props (.pclk, .presetn, .psel, .penable, .pready,
    .line_k, .remote_wake_request_n, .drive_k, .sleep_indicator_n, .clocks_enabled,
    .irq_oe, .frame_start_oe, .data_bus_oe, .bus_reset_oe, .data_set_oe);

// file: testbench/usr_host_model.sv
// usr_host_model.sv: usb host line states and application wake pin
// assumes the bench commands idle, resume and wake levels on pclk edges
`timescale 1ns/1ps
module usr_host_model (
    // commands from bench
    input wire pclk,
    input wire presetn,
    input wire host_idle,
    input wire host_resume,
    input wire app_wake,
    // line states and wake pin
    output logic line_j,
    output logic line_k,
    output logic remote_wake_request_n
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_j <= 1'b0;
            line_k <= 1'b0;
            remote_wake_request_n <= 1'b1;
        end else begin
            line_k <= host_resume;
            line_j <= host_idle & ~host_resume;
            remote_wake_request_n <= ~app_wake;
        end
    end
endmodule // usr_host_model

// file: testbench/tb_usb_device_suspend_resume_ctrl.sv
// tb_usb_device_suspend_resume_ctrl.sv: self-checking bench for the sequencer
// assumes short cycle parameters; line states come from usr_host_model
`timescale 1ns/1ps
module tb_usb_device_suspend_resume_ctrl;
    localparam int RWU = 30;
    localparam int KLEN = 20;
    typedef struct { logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e; } usr_row_t;
    usr_row_t rows [5] = '{'{12'h00c, 32'h5a5a5a5a, 32'h5a5a5a5a, 1'b0},
        '{12'h004, 32'h00000002, 32'h00000002, 1'b0}, '{12'h008, 32'h00000004, 32'h00000004, 1'b0},
        '{12'h010, 32'hffffffff, 32'h00000000, 1'b0}, '{12'h014, 32'h12345678, 32'h00000000, 1'b1}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic line_j, line_k, drive_k, remote_wake_request_n, sleep_indicator_n, clocks_enabled;
    logic interrupt_request_n, irq_oe, frame_start_oe, data_bus_oe, bus_reset_oe, data_set_oe;
    logic pullup_supply_out, settle_busy, host_idle, host_resume, app_wake;
    int error_cnt, n_checks, n;
    usr_suspend_resume #(.STABLE_CYC(20), .IDLE_CYC(10), .RWU_WAIT_CYC(RWU),
        .RESUME_K_CYC(KLEN)) u_usr_suspend_resume (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .line_j, .line_k, .drive_k,
        .remote_wake_request_n, .sleep_indicator_n, .clocks_enabled, .interrupt_request_n,
        .irq_oe, .frame_start_oe, .data_bus_oe, .bus_reset_oe, .data_set_oe,
        .pullup_supply_out, .settle_busy);
    usr_host_model u_usr_host_model (.pclk, .presetn, .host_idle, .host_resume, .app_wake,
        .line_j, .line_k, .remote_wake_request_n);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // unbounded wait: a stuck ready ends in the watchdog, not here
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        oe = data_bus_oe;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task sleep_go(input logic [31:0] po);
        apb(1'b1, 12'h000, po | 32'h1);
        apb(1'b1, 12'h000, po);
        @(posedge pclk);
        #1;
    endtask
    task wait_ce;
        n = 0;
        while (clocks_enabled !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        #1;
    endtask
    task finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, host_idle, host_resume, app_wake} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk({28'h0, sleep_indicator_n, clocks_enabled, drive_k, interrupt_request_n}, 32'hd);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk({31'h0, err}, {31'h0, rows[i].e});
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].q);
            chk({31'h0, oe}, 32'h1);
        end
        chk({31'h0, pullup_supply_out}, 32'h1);
        $display("test registers done");
        @(posedge pclk) host_idle <= 1'b1;
        repeat (18) @(posedge pclk);
        host_idle <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk({31'h0, interrupt_request_n}, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h00c, 32'h5a5a5a5b);
        sleep_go(32'h4);
        chk({sleep_indicator_n, clocks_enabled, irq_oe, frame_start_oe, data_bus_oe,
            bus_reset_oe, data_set_oe, pullup_supply_out}, 32'h01);
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h5a5a5a5b);
        chk({31'h0, oe}, 32'h0);
        @(posedge pclk) host_resume <= 1'b1;
        repeat (2) @(posedge pclk);
        host_resume <= 1'b0;
        wait_ce;
        chk({30'h0, sleep_indicator_n, interrupt_request_n}, 32'h2);
        @(posedge pclk) host_idle <= 1'b1;
        repeat (18) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd & 32'h3, 32'h2);
        apb(1'b1, 12'h000, 32'h4);
        repeat (18) @(posedge pclk);
        host_idle <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd & 32'h3, 32'h1);
        $display("test host wake done");
        apb(1'b1, 12'h00c, 32'h5a5a5a5a);
        apb(1'b1, 12'h008, 32'h6);
        sleep_go(32'h0);
        chk({26'h0, sleep_indicator_n, clocks_enabled, irq_oe, frame_start_oe, bus_reset_oe,
            data_set_oe}, 32'h0f);
        @(posedge pclk) app_wake <= 1'b1;
        repeat (2) @(posedge pclk);
        app_wake <= 1'b0;
        n = 2;
        do begin
            @(posedge pclk);
            n++;
        end while (drive_k !== 1'b1 && n < 500);
        chk({31'h0, n >= RWU}, 32'h1);
        chk({31'h0, clocks_enabled & interrupt_request_n}, 32'h1);
        n = 0;
        while (drive_k === 1'b1 && n < 500) begin
            n++;
            @(posedge pclk);
        end
        chk(n, KLEN);
        $display("test remote wake done");
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h008, 32'hf);
        #1;
        chk({31'h0, settle_busy}, 32'h1);
        repeat (15) @(posedge pclk);
        #1;
        chk({31'h0, settle_busy}, 32'h1);
        @(posedge pclk);
        #1;
        chk({31'h0, settle_busy}, 32'h0);
        repeat (4) @(posedge pclk);
        sleep_go(32'h0);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= 12'h004;
        pwdata <= 32'h1;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // next setup at once keeps psel high across the wake edge
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h010;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk(prdata, 32'h12);
        psel <= 1'b0;
        penable <= 1'b0;
        wait_ce;
        chk({30'h0, sleep_indicator_n, clocks_enabled}, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        $display("test soft restart done");
        finish_test;
    end
endmodule // tb_usb_device_suspend_resume_ctrl
